// ==== logic/fxr_pkg.sv ====
// package of constants for the 100 Mb/s receive coding path
// assumes a 125 MHz recovered symbol clock and an MII nibble consumer
// What this block does
// [R1] signal detect ignores link pulse activity
// [R2] decode MLT-3 levels into NRZI bits
// [R3] convert NRZI bits into NRZ bits
// [R4] group received bits into 5-bit symbols
// [R5] descramble by XOR with local key
// [R6] lock after twelve consecutive descrambled idles
// [R7] start 722 us hold timer at lock
// [R8] enough idle bits reload the hold timer
// [R9] hold timer expiry drops lock, resets descrambler
// [R10] align from descrambler or bypassed NRZ stream
// [R11] start pair fixes the code-group boundary
// [R12] start valid only after idles; table decode
// [R13] start pair becomes two 0101 nibbles
// [R14] stop on end pair or two idles
// [R15] link up after 395 us signal detect
// [R16] idles then non-start flags bad start
// [R17] bad start drives error and 1110
// [R18] bad start bumps false carrier counter
// [R19] two idles clear error and carrier
// [R20] key generator is 11-bit closed LFSR
// [R21] control code-groups decode per table
// [R22] control code inside data is error
// [R23] undefined pattern in packet is error
package fxr_pkg;
  // symbol codes
  localparam logic [4:0] SYM_IDLE = 5'h1F;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_H = 5'h04;
  // special nibbles
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_BAD = 4'hE;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int HOLD_US = 722;
  localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
  localparam int LINK_US = 395;
  localparam int LINK_CYC = LINK_US * CLK_MHZ;
  localparam int IDLE_LOCK_CNT = 12;
  localparam int IDLE_BITS_HOLD = 58;
  localparam int FC_CNT_W = 16;
  // receive decoder states
  typedef enum logic [1:0] {FXR_IDLE, FXR_GOT_J, FXR_DATA, FXR_BAD} fxr_state_t;
endpackage : fxr_pkg

// ==== logic/fxr_skid.sv ====
// two-entry buffer between decoder and MII output
// assumes both sides on core_clk; drain side may stall
`timescale 1ns/10ps
`default_nettype none
module fxr_skid (
  // clock and control
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [5:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [5:0] out_data
);
  logic [5:0] mem_q [2];   // storage
  logic wp_q, rp_q;        // pointers
  logic [1:0] cnt_q;       // occupancy
  wire push = in_valid && in_ready && clk_en;
  wire pop = out_valid && out_ready && clk_en;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  // pointer and count update
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= ~wp_q;
      end
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : fxr_skid
`default_nettype wire

// ==== logic/fxr_rx_pcs.sv ====
// 100 Mb/s receive coding path: MLT-3 to MII nibbles
// assumes slow control pins pass a three-stage sync; one clock core_clk
`timescale 1ns/10ps
`default_nettype none
module fxr_rx_pcs #(
  parameter int HOLD_CYC = fxr_pkg::HOLD_CYC,  // hold timer length
  parameter int LINK_CYC = fxr_pkg::LINK_CYC   // link qualify time
) (
  // clock and control
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // line side, from equaliser
  input wire logic [1:0] mlt3_level,  // 0 zero, 1 plus, 2 minus
  input wire logic sig_energy,        // analog energy detect
  input wire logic link_pulse_seen,   // 10M or auto-neg pulse activity
  input wire logic descr_bypass,      // skip descrambler
  // MII receive side
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic [3:0] rxd,
  input wire logic mii_ready,
  // status
  output logic sig_detect,
  output logic link_up,
  output logic descr_locked,
  output logic [fxr_pkg::FC_CNT_W-1:0] false_carrier_event_counter
);
  // decode 5B data codes, bit4 flags invalid
  function automatic logic [4:0] dec5(input logic [4:0] s);
    case (s)
      5'h1E: dec5 = 5'h00;
      5'h09: dec5 = 5'h01;
      5'h14: dec5 = 5'h02;
      5'h15: dec5 = 5'h03;
      5'h0A: dec5 = 5'h04;
      5'h0B: dec5 = 5'h05;
      5'h0E: dec5 = 5'h06;
      5'h0F: dec5 = 5'h07;
      5'h12: dec5 = 5'h08;
      5'h13: dec5 = 5'h09;
      5'h16: dec5 = 5'h0A;
      5'h17: dec5 = 5'h0B;
      5'h1A: dec5 = 5'h0C;
      5'h1B: dec5 = 5'h0D;
      5'h1C: dec5 = 5'h0E;
      5'h1D: dec5 = 5'h0F;
      default: dec5 = 5'h10;
    endcase
  endfunction : dec5

  // three-stage synchronisers for the slow control pins
  // the line level comes from the equaliser on core_clk itself, so it takes
  // one register only; a sync with agreement would eat every fast transition
  logic [2:0] sd_s1_q, sd_s2_q, sd_s3_q;
  logic [2:0] sd_d;       // agreed energy, pulse, bypass
  logic [1:0] lvl_q;      // registered line level
  logic [2:0] sd_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sd_s1_q <= 3'h0;
      sd_s2_q <= 3'h0;
      sd_s3_q <= 3'h0;
      lvl_q <= 2'h0;
      sd_q <= 3'h0;
    end else if (clk_en) begin
      sd_s1_q <= {descr_bypass, link_pulse_seen, sig_energy};
      sd_s2_q <= sd_s1_q;
      sd_s3_q <= sd_s2_q;
      lvl_q <= mlt3_level;
      sd_q <= sd_d;
    end
  end
  // change taken only once stages two and three agree
  assign sd_d = (sd_s2_q == sd_s3_q) ? sd_s3_q : sd_q;

  // signal detect gated off by link pulse activity
  assign sig_detect = sd_q[0] && !sd_q[1]; // R1

  // MLT-3 to NRZI: every level step toggles the NRZI level
  logic [1:0] lvl_prev_q;   // level of the previous bit
  logic nrzi_prev_q;        // NRZI level of the previous bit
  wire lvl_step = (lvl_q != lvl_prev_q);
  wire nrzi_bit = nrzi_prev_q ^ lvl_step; // R2
  // NRZI to NRZ: a toggle of the NRZI level marks a one
  wire nrz_bit = nrzi_bit ^ nrzi_prev_q; // R3

  // key generator, 11-bit closed LFSR, self-synchronised from idles
  logic [10:0] lfsr_q;
  wire key_bit = lfsr_q[10] ^ lfsr_q[8]; // R20
  wire plain_bit = nrz_bit ^ key_bit; // R5
  // while unlocked the line bit seeds the LFSR (idle plaintext is one)
  wire lfsr_in = descr_locked ? key_bit : ~nrz_bit;
  logic descr_bypass_q;     // synchronised bypass select
  assign descr_bypass_q = sd_q[2];
  wire dbit = descr_bypass_q ? nrz_bit : plain_bit; // R10

  // unaligned ten-bit shift window
  logic [9:0] win_q;        // last ten bits, newest in bit0
  logic [2:0] phase_q;      // bit counter for aligned groups
  logic aligned_q;
  logic [6:0] ones_run_q;   // consecutive ones run, saturating
  logic [5:0] idle_bits_q;  // consecutive one bits for hold reload
  logic [$clog2(HOLD_CYC+1)-1:0] hold_q;
  logic locked_q;
  assign descr_locked = locked_q;
  wire [9:0] win_d = {win_q[8:0], dbit};
  wire jk_hit = (win_d == {fxr_pkg::SYM_J, fxr_pkg::SYM_K}); // R11
  wire grp_tick = aligned_q && (phase_q == 3'h4); // R4
  wire [4:0] grp = win_d[4:0];
  wire hold_expire = locked_q && (hold_q == '0);
  wire idle_enough = (idle_bits_q >= 6'(fxr_pkg::IDLE_BITS_HOLD));

  // serial stages, descrambler lock and hold timer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lvl_prev_q <= 2'h0;
      nrzi_prev_q <= 1'b0;
      lfsr_q <= 11'h000;
      locked_q <= 1'b0;
      ones_run_q <= 7'h00;
      idle_bits_q <= 6'h00;
      hold_q <= '0;
      win_q <= 10'h000;
    end else if (clk_en) begin
      lvl_prev_q <= lvl_q;
      nrzi_prev_q <= nrzi_bit;
      lfsr_q <= {lfsr_q[9:0], lfsr_in};
      win_q <= win_d;
      ones_run_q <= (dbit && ones_run_q != 7'h7F) ? ones_run_q + 7'h01 : (dbit ? 7'h7F : 7'h00);
      idle_bits_q <= dbit ? (idle_enough ? idle_bits_q : idle_bits_q + 6'h01) : 6'h00;
      if (hold_expire) begin
        locked_q <= 1'b0; // R9
        lfsr_q <= 11'h000;
        ones_run_q <= 7'h00;
      end else if (!locked_q && ones_run_q >= 7'(fxr_pkg::IDLE_LOCK_CNT * 5)) begin
        // twelve idle groups are sixty unbroken plain ones
        locked_q <= 1'b1; // R6
        hold_q <= HOLD_CYC[$bits(hold_q)-1:0]; // R7
      end else if (locked_q) begin
        hold_q <= idle_enough ? HOLD_CYC[$bits(hold_q)-1:0] : hold_q - 1'b1; // R8
      end
    end
  end

  // link monitor: qualify signal detect
  logic [$clog2(LINK_CYC+1)-1:0] link_cnt_q;
  logic link_q;
  assign link_up = link_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_cnt_q <= '0;
      link_q <= 1'b0;
    end else if (clk_en) begin
      if (!sig_detect) begin
        link_cnt_q <= '0;
        link_q <= 1'b0;
      end else if (link_cnt_q == LINK_CYC[$bits(link_cnt_q)-1:0]) begin
        link_q <= 1'b1; // R15
      end else begin
        link_cnt_q <= link_cnt_q + 1'b1;
      end
    end
  end
  wire pcs_on = link_q && (locked_q || descr_bypass_q);

  // code-group decoder state machine
  fxr_pkg::fxr_state_t st_q, st_d;
  logic [1:0] idle_grp_q;   // consecutive idle groups, saturating at 2
  logic [5:0] out_d;        // {er, dv, nibble}
  logic out_v;
  logic [fxr_pkg::FC_CNT_W-1:0] fcc_q;
  assign false_carrier_event_counter = fcc_q;
  wire [4:0] dec = dec5(grp); // R21
  wire is_idle = (grp == fxr_pkg::SYM_IDLE);
  wire is_ctrl = is_idle || grp == fxr_pkg::SYM_J || grp == fxr_pkg::SYM_K
              || grp == fxr_pkg::SYM_T || grp == fxr_pkg::SYM_R;
  wire two_idle = is_idle && idle_grp_q != 2'h0;
  // start search: the first zero after two idle groups opens a ten-bit window;
  // a true start pair has that zero as its third bit, so the window is full
  // seven bits later and is either J/K or a bad start
  logic [2:0] ssd_cnt_q;    // bits left until the start window is full
  wire ssd_arm = st_q == fxr_pkg::FXR_IDLE && ssd_cnt_q == 3'h0 && !dbit
               && ones_run_q >= 7'h0A;
  wire ssd_chk = (ssd_cnt_q == 3'h1);
  wire jk_ok = ssd_chk && jk_hit; // R12
  wire bad_ssd = ssd_chk && !jk_hit; // R16

  // next state and output word
  always_comb begin
    st_d = st_q;
    out_d = 6'h00;
    out_v = 1'b0;
    case (st_q)
      fxr_pkg::FXR_IDLE: begin
        if (jk_ok) begin
          st_d = fxr_pkg::FXR_GOT_J; // R12
          out_d = {2'b01, fxr_pkg::NIB_PRE}; // R13
          out_v = 1'b1;
        end else if (bad_ssd) begin
          st_d = fxr_pkg::FXR_BAD;
          out_d = {2'b10, fxr_pkg::NIB_BAD}; // R17
          out_v = 1'b1;
        end
      end
      // second preamble nibble follows at once, before the first data group
      fxr_pkg::FXR_GOT_J: begin
        st_d = fxr_pkg::FXR_DATA;
        out_d = {2'b01, fxr_pkg::NIB_PRE}; // R13
        out_v = 1'b1;
      end
      fxr_pkg::FXR_DATA: begin
        if (grp_tick) begin
          if (grp == fxr_pkg::SYM_T || two_idle) begin
            st_d = fxr_pkg::FXR_IDLE; // R14
          end else begin
            out_d = {is_ctrl || dec[4], 1'b1, dec[3:0]}; // R22 R23
            out_v = 1'b1;
          end
        end
      end
      fxr_pkg::FXR_BAD: begin
        if (grp_tick) begin
          if (two_idle) begin
            st_d = fxr_pkg::FXR_IDLE; // R19
          end else begin
            out_d = {2'b10, fxr_pkg::NIB_BAD}; // R17
            out_v = 1'b1;
          end
        end
      end
      default: st_d = fxr_pkg::FXR_IDLE;
    endcase
  end

  // alignment, decoder state, counter
  logic buf_ready;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= fxr_pkg::FXR_IDLE;
      aligned_q <= 1'b0;
      phase_q <= 3'h0;
      idle_grp_q <= 2'h0;
      ssd_cnt_q <= 3'h0;
      fcc_q <= '0;
    end else if (clk_en) begin
      if (!pcs_on) begin
        // decoder held idle until link and lock (or bypass)
        st_q <= fxr_pkg::FXR_IDLE;
        aligned_q <= 1'b0;
        phase_q <= 3'h0;
        idle_grp_q <= 2'h0;
        ssd_cnt_q <= 3'h0;
      end else begin
        st_q <= st_d;
        // the start window fixes the boundary; before that, a loose phase
        if (jk_ok || bad_ssd) begin
          aligned_q <= 1'b1; // R11
          phase_q <= 3'h0;
        end else begin
          aligned_q <= 1'b1;
          phase_q <= (phase_q == 3'h4) ? 3'h0 : phase_q + 3'h1;
        end
        // start window countdown
        if (ssd_arm) begin
          ssd_cnt_q <= 3'h7;
        end else if (ssd_cnt_q != 3'h0) begin
          ssd_cnt_q <= ssd_cnt_q - 3'h1;
        end
        if (grp_tick) idle_grp_q <= is_idle ? (idle_grp_q == 2'h2 ? 2'h2 : idle_grp_q + 2'h1) : 2'h0;
        if (bad_ssd && fcc_q != '1) fcc_q <= fcc_q + 1'b1; // R18
      end
    end
  end

  // buffer between decoder and MII; word lost only if both slots full
  logic [5:0] buf_q;
  logic buf_v;
  fxr_skid u_skid (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_valid(out_v),
    .in_ready(buf_ready),
    .in_data(out_d),
    .out_valid(buf_v),
    .out_ready(mii_ready),
    .out_data(buf_q)
  );
  assign rx_dv = buf_v && buf_q[4];
  assign rx_er = buf_v && buf_q[5]; // R17
  assign rxd = buf_v ? buf_q[3:0] : 4'h0;
  assign crs = (st_q != fxr_pkg::FXR_IDLE) || buf_v; // R19

  // checks
  chk_lock_clears: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && hold_expire |=> !locked_q) else $error("lock kept after expiry"); // R9
  chk_sd_pulses: assert property (@(posedge core_clk) disable iff (reset)
    sd_q[1] |-> !sig_detect) else $error("detect on link pulses"); // R1
  chk_link_needs_sd: assert property (@(posedge core_clk) disable iff (reset)
    link_up |-> $past(sig_detect)) else $error("link without detect"); // R15
  chk_fc_count: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && bad_ssd && pcs_on && fcc_q != '1 |=> fcc_q == $past(fcc_q) + 1'b1)
    else $error("counter missed bad start"); // R18
  chk_bad_nib: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && st_q == fxr_pkg::FXR_BAD && out_v |-> out_d == {2'b10, fxr_pkg::NIB_BAD})
    else $error("bad start nibble wrong"); // R17
  chk_pre_nib: assert property (@(posedge core_clk) disable iff (reset)
    st_q == fxr_pkg::FXR_GOT_J |-> out_v && out_d == {2'b01, fxr_pkg::NIB_PRE})
    else $error("preamble nibble wrong"); // R13
  chk_jk_preamble: assert property (@(posedge core_clk) disable iff (reset)
    st_q == fxr_pkg::FXR_IDLE && jk_ok |-> out_v && out_d == {2'b01, fxr_pkg::NIB_PRE})
    else $error("start pair not replaced"); // R12
  chk_lock_hold: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && $rose(locked_q) |-> hold_q == HOLD_CYC[$bits(hold_q)-1:0])
    else $error("hold not loaded"); // R7
  chk_nrz_conv: assert property (@(posedge core_clk) disable iff (reset)
    nrz_bit == (lvl_q != lvl_prev_q)) else $error("nrz mismatch"); // R3
  cov_lock: cover property (@(posedge core_clk) $rose(locked_q));
  cov_frame: cover property (@(posedge core_clk) st_q == fxr_pkg::FXR_DATA);
  cov_bad: cover property (@(posedge core_clk) bad_ssd);
  cov_expire: cover property (@(posedge core_clk) hold_expire);
endmodule : fxr_rx_pcs
`default_nettype wire

// ==== sim/fxr_mac_model.sv ====
// behavioural mac taking nibbles off the mii receive side
// assumes core_clk shared with the device; stalls on a fixed pattern
`timescale 1ns/10ps
`default_nettype none
module fxr_mac_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // mii receive from the device
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic [3:0] rxd,
  output logic mii_ready,
  // stall pattern enable
  input wire logic stall_en
);
  logic [4:0] got[$];  // words taken, {rx_er, rxd}
  int cyc = 0;         // free cycle count for the stall pattern
  initial mii_ready = 1'b1;
  // take the head word when ready, then move ready just after the edge
  always @(posedge core_clk) begin
    if (!reset && mii_ready && (rx_dv || rx_er)) begin
      got.push_back({rx_er, rxd});
    end
    cyc = cyc + 1;
    // two stalled cycles of five: slower than never, faster than symbols
    #1 mii_ready = !(stall_en && (cyc % 5 < 2));
  end
endmodule : fxr_mac_model
`default_nettype wire

// ==== sim/tb_fast_ethernet_rx_pcs.sv ====
// self-checking bench for the receive coding path
// assumes fxr_pkg, the design and the mac model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_fast_ethernet_rx_pcs;
  // stimulus
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] mlt3_level = 2'h0;
  logic sig_energy = 1'b0;
  logic link_pulse_seen = 1'b0;
  logic descr_bypass = 1'b1;
  // design outputs and the mac ready
  logic rx_dv, rx_er, crs, mii_ready, sig_detect, link_up, descr_locked;
  logic [3:0] rxd;
  logic [fxr_pkg::FC_CNT_W-1:0] fc_cnt;
  // line encoder: mlt-3 phase and scrambler register
  logic [1:0] phase = 2'h0;
  logic [10:0] scr = 11'h5A3;
  int failures = 0;
  int num_checks = 0;
  // data code-groups for nibbles 0 to F
  localparam logic [4:0] DATA5 [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  always #4 core_clk = ~core_clk;
  // device under test, short timers
  fxr_rx_pcs #(.HOLD_CYC(200), .LINK_CYC(50)) fxr_rx_pcs_inst (
    .core_clk(core_clk), .reset(reset), .clk_en(1'b1), .mlt3_level(mlt3_level),
    .sig_energy(sig_energy), .link_pulse_seen(link_pulse_seen),
    .descr_bypass(descr_bypass), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .rxd(rxd),
    .mii_ready(mii_ready), .sig_detect(sig_detect), .link_up(link_up),
    .descr_locked(descr_locked), .false_carrier_event_counter(fc_cnt));
  // far side mac
  fxr_mac_model fxr_mac_model_inst (
    .core_clk(core_clk), .reset(reset), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
    .mii_ready(mii_ready), .stall_en(1'b1));
  // compare one flag
  task automatic chk1(input logic act, input logic exp);
    num_checks++;
    if (act !== exp) begin
      failures++;
      $display("[ERR] %0t flag got %b want %b", $time, act, exp);
    end
  endtask : chk1
  // compare one taken word {rx_er, rxd}
  task automatic chk5(input logic [4:0] act, input logic [4:0] exp);
    num_checks++;
    if (act !== exp) begin
      failures++;
      $display("[ERR] %0t word got %h want %h", $time, act, exp);
    end
  endtask : chk5
  // one nrz bit onto the line; a one advances the mlt-3 phase via nrzi
  task automatic send_bit(input logic b);
    logic k;
    k = scr[10] ^ scr[8];
    scr = {scr[9:0], k};
    if (!descr_bypass) begin
      b = b ^ k;  // scrambled only when the descrambler is in use
    end
    if (b) begin
      phase = phase + 2'h1;
    end
    @(posedge core_clk);
    #1 mlt3_level = phase[0] ? (phase[1] ? 2'h2 : 2'h1) : 2'h0;
  endtask : send_bit
  // n copies of one code-group, first bit is the msb
  task automatic send_n(input logic [4:0] g, input int n);
    repeat (n) begin
      for (int i = 4; i >= 0; i--) begin
        send_bit(g[i]);
      end
    end
  endtask : send_n
  // link pulses must not qualify, plain energy must
  task automatic t_sigdet();
    #1 link_pulse_seen = 1'b1;
    sig_energy = 1'b1;
    repeat (80) @(posedge core_clk);
    chk1(sig_detect, 1'b0);
    chk1(link_up, 1'b0);
    #1 link_pulse_seen = 1'b0;
    repeat (40) @(posedge core_clk);
    chk1(sig_detect, 1'b1);
    chk1(link_up, 1'b0);
    repeat (30) @(posedge core_clk);
    chk1(link_up, 1'b1);
  endtask : t_sigdet
  // whole frame through bypass: preamble, all sixteen nibbles, end pair
  task automatic t_frame();
    fxr_mac_model_inst.got.delete();
    send_n(fxr_pkg::SYM_IDLE, 6);
    send_n(fxr_pkg::SYM_J, 1);
    send_n(fxr_pkg::SYM_K, 1);
    for (int i = 0; i < 16; i++) begin
      send_n(DATA5[i], 1);
    end
    send_n(fxr_pkg::SYM_T, 1);
    send_n(fxr_pkg::SYM_R, 1);
    send_n(fxr_pkg::SYM_IDLE, 6);
    send_n(fxr_pkg::SYM_IDLE, 4);
    chk1(fxr_mac_model_inst.got.size() == 18, 1'b1);
    if (fxr_mac_model_inst.got.size() >= 18) begin
      chk5(fxr_mac_model_inst.got[0], {1'b0, fxr_pkg::NIB_PRE});
      chk5(fxr_mac_model_inst.got[1], {1'b0, fxr_pkg::NIB_PRE});
      for (int i = 0; i < 16; i++) begin
        chk5(fxr_mac_model_inst.got[i+2], {1'b0, 4'(i)});
      end
    end
    chk1(crs, 1'b0);
  endtask : t_frame
  // idle and undefined codes inside the data field
  task automatic t_invalid();
    fxr_mac_model_inst.got.delete();
    send_n(fxr_pkg::SYM_IDLE, 6);
    send_n(fxr_pkg::SYM_J, 1);
    send_n(fxr_pkg::SYM_K, 1);
    send_n(DATA5[1], 1);
    send_n(fxr_pkg::SYM_IDLE, 1);
    send_n(DATA5[2], 1);
    send_n(5'h00, 1);
    send_n(fxr_pkg::SYM_T, 1);
    send_n(fxr_pkg::SYM_R, 1);
    send_n(fxr_pkg::SYM_IDLE, 6);
    send_n(fxr_pkg::SYM_IDLE, 4);
    chk1(fxr_mac_model_inst.got.size() >= 6, 1'b1);
    if (fxr_mac_model_inst.got.size() >= 6) begin
      chk5(fxr_mac_model_inst.got[2], 5'h01);
      chk1(fxr_mac_model_inst.got[3][4], 1'b1);
      chk5(fxr_mac_model_inst.got[4], 5'h02);
      chk1(fxr_mac_model_inst.got[5][4], 1'b1);
    end
  endtask : t_invalid
  // data straight after idles with no start pair
  task automatic t_badssd();
    logic [fxr_pkg::FC_CNT_W-1:0] fc0;
    fc0 = fc_cnt;
    fxr_mac_model_inst.got.delete();
    send_n(fxr_pkg::SYM_IDLE, 6);
    send_n(DATA5[4], 4);
    send_n(fxr_pkg::SYM_IDLE, 6);
    send_n(fxr_pkg::SYM_IDLE, 4);
    chk1(fxr_mac_model_inst.got.size() >= 4, 1'b1);
    foreach (fxr_mac_model_inst.got[i]) begin
      chk5(fxr_mac_model_inst.got[i], {1'b1, fxr_pkg::NIB_BAD});
    end
    chk1(fc_cnt == fc0 + 1'b1, 1'b1);
    chk1(rx_er, 1'b0);
    chk1(crs, 1'b0);
  endtask : t_badssd
  // scrambled idles lock, idles keep it, data alone loses it
  task automatic t_lock();
    #1 descr_bypass = 1'b0;
    send_n(fxr_pkg::SYM_IDLE, 20);
    repeat (10) @(posedge core_clk);
    chk1(descr_locked, 1'b1);
    send_n(fxr_pkg::SYM_IDLE, 60);
    chk1(descr_locked, 1'b1);
    send_n(DATA5[5], 20);
    chk1(descr_locked, 1'b1);
    send_n(DATA5[5], 60);
    chk1(descr_locked, 1'b0);
  endtask : t_lock
  // counts and verdict, then stop
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge core_clk);
    #1 reset = 1'b0;
    t_sigdet();
    t_frame();
    t_invalid();
    t_badssd();
    t_lock();
    final_report();
  end
  // watchdog well beyond the expected run
  initial begin
    #(8 * 20000);
    failures++;
    final_report();
  end
endmodule : tb_fast_ethernet_rx_pcs
`default_nettype wire
